// ---- core/dlpc_cfg.svh ----
`ifndef DLPC_CFG_SVH
`define DLPC_CFG_SVH
// Select code fields.
`define DLPC_SEL_COLOUR_LSB 0
`define DLPC_SEL_GROUP_LSB 2
// Select code for driver disabled mode.
`define DLPC_SEL_OFF 4'h0
// Width of each drive toggle phase, in clock cycles.
`define DLPC_TOGGLE_CYC 2
// Pulse width limit reset value per colour, in clock cycles.
`define DLPC_PW_LIMIT_RST 16'h0400
// Comparator holdoff reset value, in clock cycles.
`define DLPC_HOLDOFF_RST 16'h0040
// Controller wait after pulse end and before first release, in cycles.
`define DLPC_CTRL_WAIT_RST 16'h0020
`define DLPC_CTRL_PRE_RST 16'h0010
// Controller register offsets.
`define DLPC_REG_CTRL 4'h0
`define DLPC_REG_SEL 4'h1
`define DLPC_REG_COUNT 4'h2
`define DLPC_REG_PRE 4'h3
`define DLPC_REG_WAIT 4'h4
`define DLPC_REG_STATUS 4'h5
`endif

// ---- core/dlpc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dlpc_cfg.svh"
module dlpc_ctrl
  import dlpc_pkg::*;
#(
  parameter int TW = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Software register port.
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Link to the device.
  dlpc_link_if.ctrl link
);
  typedef enum logic [2:0] {
    C_IDLE, C_PRE, C_LIGHT, C_WAIT, C_DONE
  } dlpc_ctrl_state_t;

  dlpc_ctrl_state_t st_ff;
  logic go_ff, en_ff, req_ff;
  logic [3:0] sel_ff;
  logic [7:0] count_ff, issued_ff;
  logic [TW-1:0] pre_ff, wait_ff, tmr_ff;
  logic [31:0] rdata_ff;
  logic cmp_s, cmp_prev_ff;

  dlpc_sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_cmp (
    .clock(clock), .rst(rst), .d(link.photo_compare_out), .q(cmp_s)
  );

  // Configuration registers; start bit is a self-clearing pulse.
  always_ff @(posedge clock) begin
    if (rst) begin
      go_ff <= 1'b0;
      sel_ff <= 4'h0;
      count_ff <= 8'h01;
      pre_ff <= TW'(`DLPC_CTRL_PRE_RST);
      wait_ff <= TW'(`DLPC_CTRL_WAIT_RST);
    end else begin
      go_ff <= wr && addr == `DLPC_REG_CTRL && wdata[0];
      if (wr && addr == `DLPC_REG_SEL) sel_ff <= wdata[3:0];
      if (wr && addr == `DLPC_REG_COUNT) count_ff <= wdata[7:0];
      if (wr && addr == `DLPC_REG_PRE) pre_ff <= wdata[TW-1:0];
      if (wr && addr == `DLPC_REG_WAIT) wait_ff <= wdata[TW-1:0];
    end
  end

  // Read data one cycle after the strobe.
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= 32'h0;
    end else if (rd) begin
      unique case (addr)
        `DLPC_REG_SEL: rdata_ff <= {28'h0, sel_ff};
        `DLPC_REG_COUNT: rdata_ff <= {24'h0, count_ff};
        `DLPC_REG_PRE: rdata_ff <= 32'(pre_ff);
        `DLPC_REG_WAIT: rdata_ff <= 32'(wait_ff);
        `DLPC_REG_STATUS: rdata_ff <= {23'h0, st_ff != C_IDLE, issued_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end else begin
      rdata_ff <= 32'h0;
    end
  end

  // Bit slice sequence: enable, release, wait, repeat until count met.
  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= C_IDLE;
      en_ff <= 1'b0;
      req_ff <= 1'b1;
      tmr_ff <= '0;
      issued_ff <= 8'h00;
      cmp_prev_ff <= 1'b1;
    end else begin
      cmp_prev_ff <= cmp_s;
      unique case (st_ff)
        // Off and blanking codes run no pulses, so no slice is started.
        C_IDLE: if (go_ff && count_ff != 8'h00 &&
                    sel_ff[1:0] != 2'h0) begin
          en_ff <= 1'b1;
          issued_ff <= 8'h00;
          tmr_ff <= pre_ff;
          st_ff <= C_PRE;
        end
        C_PRE: if (tmr_ff == '0) begin
          req_ff <= 1'b0;
          issued_ff <= issued_ff + 8'h01;
          st_ff <= C_LIGHT;
        end else begin
          tmr_ff <= tmr_ff - 1'b1;
        end
        C_LIGHT: if (cmp_prev_ff && !cmp_s) begin
          req_ff <= 1'b1;
          tmr_ff <= wait_ff;
          st_ff <= C_WAIT;
        end
        C_WAIT: if (tmr_ff != '0) begin
          tmr_ff <= tmr_ff - 1'b1;
        end else if (issued_ff < count_ff) begin
          req_ff <= 1'b0;
          issued_ff <= issued_ff + 8'h01;
          st_ff <= C_LIGHT;
        end else begin
          en_ff <= 1'b0;
          st_ff <= C_DONE;
        end
        C_DONE: st_ff <= C_IDLE;
      endcase
    end
  end

  assign link.pulse_mode_en = en_ff;
  assign link.shunt_req = req_ff;
  assign link.led_select_code = sel_ff;
  assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ---- core/dlpc_device.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dlpc_cfg.svh"
module dlpc_device
  import dlpc_pkg::*;
#(
  parameter int TW = 16,
  parameter int DACW = 10
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Link to the controller.
  dlpc_link_if.device link,
  // Raw photo comparator from the analogue front end.
  input wire logic photo_cmp_raw,
  // Settings: width limits per colour, holdoff, low brightness.
  input wire logic [3*TW-1:0] pw_limit,
  input wire logic [TW-1:0] compare_holdoff_time,
  input wire logic low_bright_mode,
  // Settings: peak current per colour, threshold per group and colour.
  input wire logic [3*DACW-1:0] peak_cfg,
  input wire logic [12*DACW-1:0] thresh_cfg,
  // Outputs to the power stage.
  output logic low_res_shunt_on,
  output logic led_drive_on,
  output logic offtime_pin,
  output logic [2:0] colour_sel,
  output logic blank_sel,
  output logic [DACW-1:0] peak_limit_dac,
  output logic [DACW-1:0] thresh_dac,
  output logic pulse_timeout
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_CHARGE, ST_TOG_OFF, ST_TOG_ON, ST_LIGHT
  } dlpc_dev_state_t;

  logic [5:0] raw_in;
  logic [5:0] sync_q;
  logic en_s, req_s, cmp_s;
  logic [3:0] sel_s;
  dlpc_dev_state_t state_ff, nxt_state;
  logic req_prev_ff, cmp_prev_ff;
  logic [TW-1:0] pw_cnt_ff, hold_cnt_ff;
  logic [1:0] tog_cnt_ff;
  logic hold_act_ff, cmp_out_ff;
  logic shunt_ff, drive_ff, offtime_pin_ff, tmo_ff, blank_ff;
  logic [2:0] csel_ff;
  logic [DACW-1:0] peak_ff, thr_ff;
  logic [1:0] colour, group;
  logic req_fall, cmp_fall, sel_off, tmo_hit;
  logic [1:0] cidx;

  // All link inputs and the comparator cross into the clock domain.
  assign raw_in = {link.pulse_mode_en, link.shunt_req,
                   link.led_select_code};
  // Idle levels: enable low, shunt request high, select code off.
  dlpc_sync2 #(.WIDTH(6), .RST_VAL(6'h10)) u_sync_link (
    .clock(clock), .rst(rst), .d(raw_in), .q(sync_q)
  );
  dlpc_sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_cmp (
    .clock(clock), .rst(rst), .d(photo_cmp_raw), .q(cmp_s)
  );
  assign en_s = sync_q[5];
  assign req_s = sync_q[4];
  assign sel_s = sync_q[3:0];

  // Select code decode into colour and group.
  assign colour = sel_s[`DLPC_SEL_COLOUR_LSB +: 2];
  assign group = sel_s[`DLPC_SEL_GROUP_LSB +: 2];
  assign sel_off = (sel_s == `DLPC_SEL_OFF);
  assign cidx = (colour == DLPC_BLANK) ? (group - 2'h1) : (colour - 2'h1);
  assign req_fall = req_prev_ff && !req_s;
  assign cmp_fall = cmp_prev_ff && !cmp_s && !hold_act_ff;
  assign tmo_hit = (state_ff == ST_LIGHT) && (pw_cnt_ff == '0);

  // Edge history for request and comparator.
  always_ff @(posedge clock) begin
    if (rst) begin
      req_prev_ff <= 1'b1;
      cmp_prev_ff <= 1'b1;
    end else begin
      req_prev_ff <= req_s;
      cmp_prev_ff <= cmp_s;
    end
  end

  // Pulse sequencer state register.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Next state for the pulse sequence.
  always_comb begin
    nxt_state = state_ff;
    if (sel_off || !en_s) begin
      nxt_state = ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: if (colour != DLPC_BLANK) nxt_state = ST_CHARGE;
        ST_CHARGE: if (req_fall) nxt_state = ST_TOG_OFF;
        ST_TOG_OFF: if (tog_cnt_ff == 2'h0) nxt_state = ST_TOG_ON;
        ST_TOG_ON: if (tog_cnt_ff == 2'h0) nxt_state = ST_LIGHT;
        ST_LIGHT: if (cmp_fall || tmo_hit) nxt_state = ST_CHARGE;
      endcase
    end
  end

  // Toggle phase timer, reloaded on entry to each phase.
  always_ff @(posedge clock) begin
    if (rst) begin
      tog_cnt_ff <= 2'h0;
    end else if (nxt_state != state_ff) begin
      tog_cnt_ff <= 2'(`DLPC_TOGGLE_CYC - 1);
    end else if (tog_cnt_ff != 2'h0) begin
      tog_cnt_ff <= tog_cnt_ff - 2'h1;
    end
  end

  // Pulse width counter, reloaded from the active colour limit.
  always_ff @(posedge clock) begin
    if (rst) begin
      pw_cnt_ff <= '0;
    end else if (state_ff == ST_TOG_ON && nxt_state == ST_LIGHT) begin
      pw_cnt_ff <= pw_limit[cidx*TW +: TW];
    end else if (state_ff == ST_LIGHT && pw_cnt_ff != '0) begin
      pw_cnt_ff <= pw_cnt_ff - 1'b1;
    end
  end

  // Holdoff after the first comparator fall; edges meanwhile ignored.
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_cnt_ff <= '0;
      hold_act_ff <= 1'b0;
    end else if (cmp_fall) begin
      hold_cnt_ff <= compare_holdoff_time;
      hold_act_ff <= (compare_holdoff_time != '0);
    end else if (hold_act_ff) begin
      hold_cnt_ff <= hold_cnt_ff - 1'b1;
      hold_act_ff <= (hold_cnt_ff > 1);
    end
  end

  // Filtered comparator to the controller: low marks pulse end.
  always_ff @(posedge clock) begin
    if (rst) begin
      cmp_out_ff <= 1'b1;
    end else if (cmp_fall || tmo_hit) begin
      cmp_out_ff <= 1'b0;
    end else if (!hold_act_ff && state_ff != ST_LIGHT) begin
      cmp_out_ff <= cmp_s;
    end
  end

  // Shunt, drive and off-time sync outputs.
  always_ff @(posedge clock) begin
    if (rst) begin
      shunt_ff <= 1'b1;
      drive_ff <= 1'b0;
      offtime_pin_ff <= 1'b0;
      tmo_ff <= 1'b0;
    end else begin
      shunt_ff <= !(nxt_state inside {ST_TOG_OFF, ST_TOG_ON, ST_LIGHT});
      drive_ff <= (nxt_state != ST_IDLE) && (nxt_state != ST_TOG_OFF);
      offtime_pin_ff <= !low_bright_mode && (state_ff == ST_LIGHT);
      tmo_ff <= tmo_hit && !cmp_fall;
    end
  end

  // Colour select, blanking and DAC settings by group and colour.
  always_ff @(posedge clock) begin
    if (rst) begin
      csel_ff <= 3'h0;
      blank_ff <= 1'b0;
      peak_ff <= '0;
      thr_ff <= '0;
    end else begin
      csel_ff <= 3'h0;
      blank_ff <= 1'b0;
      if (!sel_off && colour == DLPC_BLANK) begin
        blank_ff <= 1'b1;
      end else if (!sel_off) begin
        csel_ff <= 3'(1 << cidx);
      end
      if (!sel_off) begin
        peak_ff <= peak_cfg[cidx*DACW +: DACW];
        thr_ff <= thresh_cfg[(group*3 + cidx)*DACW +: DACW];
      end
    end
  end
  assign blank_sel = blank_ff;
  // Outputs driven straight from flops.
  assign low_res_shunt_on = shunt_ff;
  assign led_drive_on = drive_ff;
  assign offtime_pin = offtime_pin_ff;
  assign colour_sel = csel_ff;
  assign peak_limit_dac = peak_ff;
  assign thresh_dac = thr_ff;
  assign pulse_timeout = tmo_ff;
  assign link.photo_compare_out = cmp_out_ff;
endmodule
`default_nettype wire

// ---- core/dlpc_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dlpc_link_if;
  logic pulse_mode_en;
  logic shunt_req;
  logic [3:0] led_select_code;
  logic photo_compare_out;
  modport device (
    input pulse_mode_en, shunt_req, led_select_code,
    output photo_compare_out
  );
  modport ctrl (
    output pulse_mode_en, shunt_req, led_select_code,
    input photo_compare_out
  );
endinterface
`default_nettype wire

// ---- core/dlpc_pkg.sv ----
package dlpc_pkg;
  // Colour decoded from the low two select bits.
  typedef enum logic [1:0] {
    DLPC_BLANK = 2'h0,
    DLPC_RED = 2'h1,
    DLPC_GREEN = 2'h2,
    DLPC_BLUE = 2'h3
  } dlpc_colour_t;
endpackage

// ---- core/dlpc_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module dlpc_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Asynchronous input and synchronised output.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;
  // Two flops; the first is read only by the second. Both reset to the
  // idle level of the pin, so no false edge shows after reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule
`default_nettype wire

// ---- verification/dlpc_link_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module dlpc_link_monitor (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Link between controller and device.
  input wire logic pulse_mode_en,
  input wire logic shunt_req,
  input wire logic [3:0] led_select_code,
  input wire logic photo_compare_out,
  // Device mode input and power stage outputs.
  input wire logic low_bright_mode,
  input wire logic low_res_shunt_on,
  input wire logic led_drive_on,
  input wire logic offtime_pin,
  input wire logic [2:0] colour_sel,
  input wire logic blank_sel,
  input wire logic pulse_timeout
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // A colour code carries non-zero low bits.
  wire sel_on = led_select_code[1:0] != 2'h0;

  // Settled codes must reach the power stage within the sync delay.
  chk_off_idle: assert property (
    (led_select_code == 4'h0)[*5] |->
    low_res_shunt_on && !led_drive_on && colour_sel == 3'h0)
    else $error("off code left shunt or drive wrong");
  chk_colour_decode: assert property (
    (pulse_mode_en && sel_on && $stable(led_select_code))[*5] |->
    colour_sel == 3'(3'h1 << (led_select_code[1:0] - 2'h1)))
    else $error("colour select does not match code");
  chk_blank_decode: assert property (
    (!sel_on && $stable(led_select_code))[*5] |->
    blank_sel == (led_select_code != 4'h0))
    else $error("blanking select does not match code");
  // Pulse start and the on, off, on drive toggle.
  chk_drive_start: assert property (
    $rose(pulse_mode_en) && sel_on && shunt_req |-> ##[1:6] led_drive_on)
    else $error("drive did not start on enable");
  chk_shunt_release: assert property (
    $fell(shunt_req) && pulse_mode_en && sel_on |->
    ##[2:6] !low_res_shunt_on)
    else $error("shunt not released on request");
  chk_drive_toggle: assert property (
    $fell(shunt_req) && pulse_mode_en && sel_on |->
    ##[2:6] !led_drive_on ##[1:4] led_drive_on)
    else $error("drive toggle missing");
  // Pulse end by light or by width limit, holdoff gap, and no off time output in low brightness.
  chk_pulse_end: assert property (
    $fell(photo_compare_out) |-> ##[0:4] low_res_shunt_on)
    else $error("shunt not closed at pulse end");
  chk_timeout_end: assert property (
    pulse_timeout |-> ##[0:4] low_res_shunt_on)
    else $error("shunt not closed at width limit");
  chk_holdoff_gap: assert property (
    $fell(photo_compare_out) |=> (!$fell(photo_compare_out))[*8])
    else $error("comparator fall passed inside holdoff");
  chk_offtime_quiet: assert property (
    low_bright_mode[*3] |-> !offtime_pin)
    else $error("off time output active in low brightness");
endmodule
`default_nettype wire

// ---- verification/tb_discontinuous_led_pulse_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_discontinuous_led_pulse_ctrl;
  import dlpc_pkg::*;
  typedef struct packed {
    logic [2:0] col;
    logic [15:0] lim;
    logic [9:0] pk;
    logic [9:0] th;
  } dlpc_note_t;
  // Width limits per colour: red 40, green 48, blue 56 cycles.
  localparam logic [47:0] PWL = {16'h0038, 16'h0030, 16'h0028};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic raw = 1'b1;
  logic low_bright = 1'b0;
  logic dark = 1'b0;
  logic [29:0] peak = 30'h0;
  logic [119:0] thr = 120'h0;
  logic shunt, drive, offt, blank, p_to;
  logic [2:0] col;
  logic [9:0] pk_dac, th_dac;
  logic [31:0] rng = 32'h0000BEBA;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int low_cnt = 0;
  int seen_lim = 0;
  dlpc_note_t notes[$];

  dlpc_link_if link ();
  dlpc_device i_dlpc_device (.clock(clock), .rst(rst), .link(link.device),
    .photo_cmp_raw(raw), .pw_limit(PWL), .compare_holdoff_time(16'h0010),
    .low_bright_mode(low_bright), .peak_cfg(peak), .thresh_cfg(thr),
    .low_res_shunt_on(shunt), .led_drive_on(drive), .offtime_pin(offt),
    .colour_sel(col), .blank_sel(blank), .peak_limit_dac(pk_dac),
    .thresh_dac(th_dac), .pulse_timeout(p_to));
  dlpc_ctrl i_dlpc_ctrl (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link.ctrl));
  dlpc_link_monitor i_dlpc_link_monitor (.clock(clock), .rst(rst),
    .pulse_mode_en(link.pulse_mode_en), .shunt_req(link.shunt_req),
    .led_select_code(link.led_select_code),
    .photo_compare_out(link.photo_compare_out),
    .low_bright_mode(low_bright), .low_res_shunt_on(shunt),
    .led_drive_on(drive), .offtime_pin(offt), .colour_sel(col),
    .blank_sel(blank), .pulse_timeout(p_to));

  // Clock at 200 MHz.
  initial begin
    forever #2.5 clock = ~clock;
  end

  // Fixed-seed xorshift source for stimulus values.
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Compares one value and counts the outcome.
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Register port cycles; entered right after a rising edge.
  task automatic reg_wr(logic [3:0] a, logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic reg_rd(logic [3:0] a, output logic [31:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clock);
  endtask

  // One bit slice: note the expected pulses, program and start it.
  task automatic slice(logic [3:0] code, int cnt, logic no_light);
    logic [31:0] d;
    int c;
    c = code[1:0];
    dark = no_light;
    low_bright <= 1'(rnd() % 2);
    for (int i = 0; i < cnt && c != 0; i++) begin
      notes.push_back({3'(1 << (c - 1)),
        no_light ? PWL[(c - 1) * 16 +: 16] : 16'h0,
        peak[(c - 1) * 10 +: 10], thr[(code[3:2] * 3 + c - 1) * 10 +: 10]});
    end
    reg_wr(4'h1, 32'(code));
    reg_wr(4'h2, 32'(cnt));
    reg_wr(4'h0, 32'h1);
    repeat (4) @(posedge clock);
    d = 32'h100;
    for (int w = 0; w < 4000 && d[8]; w++) reg_rd(4'h5, d);
    if (c != 0) check("issued", 16'(cnt), 16'(d[7:0]));
    repeat (8) @(posedge clock);
    $display("slice %h done", code);
  endtask

  // Comparator stand-in: light crosses after a random delay, followed
  // by a glitch that the holdoff filter has to swallow.
  initial begin
    forever begin
      @(posedge clock iff (shunt === 1'b0));
      if (!dark) begin
        repeat (4 + rnd() % 12) @(posedge clock);
        raw <= 1'b0;
        @(posedge clock);
        raw <= 1'b1;
        @(posedge clock);
        raw <= 1'b0;
      end
      @(posedge clock iff (shunt === 1'b1));
      repeat (2) @(posedge clock);
      raw <= 1'b1;
    end
  end

  // Measures how long LED current flowed (shunt open, drive on) before a
  // width timeout; the count is taken before the timeout clears it.
  always @(posedge clock) begin
    if (p_to === 1'b1) seen_lim = low_cnt;
    low_cnt = shunt ? 0 : low_cnt + int'(drive);
  end

  // Each completed pulse takes the oldest note and checks it.
  initial begin
    dlpc_note_t n;
    forever begin
      @(negedge link.photo_compare_out);
      repeat (3) @(posedge clock);
      if (notes.size() == 0) begin
        check("unexpected pulse", 16'h0, 16'h1);
      end else begin
        n = notes.pop_front();
        check("colour", 16'(n.col), 16'(col));
        check("peak dac", 16'(n.pk), 16'(pk_dac));
        check("thresh dac", 16'(n.th), 16'(th_dac));
        if (n.lim == 16'h0) begin
          check("timeout", 16'h0, 16'(seen_lim));
        end else begin
          check("width", 16'h1, 16'(seen_lim + 2 >= n.lim &&
            seen_lim <= n.lim + 4));
        end
        seen_lim = 0;
      end
    end
  end

  // Hang guard.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // Main sequence: reset, register checks, every code, width limits.
  initial begin
    logic [31:0] d;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    peak <= 30'(rnd());
    thr <= 120'({rnd(), rnd(), rnd(), rnd()});
    @(posedge clock);
    reg_rd(4'h2, d);
    check("count reset", 16'h0001, d[15:0]);
    reg_rd(4'h3, d);
    check("pre reset", 16'h0010, d[15:0]);
    reg_rd(4'h4, d);
    check("wait reset", 16'h0020, d[15:0]);
    reg_wr(4'hF, 32'hFFFFFFFF);
    reg_rd(4'hF, d);
    check("unmapped", 16'h0000, d[15:0]);
    for (int i = 0; i < 16; i++) slice(4'(i), 1 + rnd() % 3, 1'b0);
    slice(4'h1, 1, 1'b1);
    slice(4'h6, 2, 1'b1);
    slice(4'hF, 1, 1'b1);
    check("notes left", 16'h0, 16'(notes.size()));
    wrap_up();
  end
endmodule
`default_nettype wire
